// ---- rtl/cbt_exec.sv ----
// Execution unit for bit, transfer and status flag operations
//
// Implementation choices: the address-and-strobe port and the address map.
`timescale 1ns/1ps
module cbt_exec
  import cbt_pkg::*;
(
  // Clock, reset and enable
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Command port
  input wire logic op_valid_i,
  input wire cbt_op_t op_code_i,
  input wire logic [4:0] op_reg_i,
  input wire logic [5:0] op_io_addr_i,
  input wire logic [2:0] op_bit_i,
  input wire logic op_flag_val_i,
  output logic op_ready_o,
  output logic op_done_o,
  // Program memory write port
  output logic pm_wr_o,
  output logic [23:0] pm_addr_o,
  output logic [15:0] pm_data_o,
  // Software register port
  input wire logic [7:0] sw_addr_i,
  input wire logic [7:0] sw_wdata_i,
  input wire logic sw_wr_i,
  input wire logic sw_rd_i,
  output logic [7:0] sw_rdata_o,
  // Status view
  output logic [7:0] status_flags_register_o
);
  // Whole module state
  typedef struct packed {
    cbt_fsm_t state;
    cbt_op_t op;
    logic [4:0] rd;
    logic [GPR_COUNT-1:0][7:0] gpr;
    logic [IO_COUNT-1:0][7:0] io;
    logic [7:0] status_flags_register;
    logic [7:0] ext;
    logic [15:0] sp;
    logic [7:0] rdata;
    logic done;
    logic pm_wr;
    logic [23:0] pm_addr;
    logic [15:0] pm_data;
  } cbt_regs_t;

  cbt_regs_t r_reg;
  cbt_regs_t r_next;
  logic mem_wr;
  logic [DMEM_AW-1:0] mem_addr;
  logic [7:0] mem_wdata;
  logic [7:0] mem_rdata;
  logic [7:0] src;
  logic [7:0] res;
  logic [15:0] zptr;
  logic [15:0] zsum;
  logic [7:0] io_idx;

  // Replace one bit of a byte
  function automatic logic [7:0] put_bit(input logic [7:0] v, input logic [2:0] idx,
                                         input logic b);
    logic [7:0] t;
    t = v;
    t[idx] = b;
    return t;
  endfunction

  // Common flag update of both rotates
  function automatic logic [7:0] rot_flags(input logic [7:0] s, input logic [7:0] q,
                                           input logic c);
    logic [7:0] t;
    t = s;
    t[FLAG_C] = c;
    t[FLAG_N] = q[7];
    t[FLAG_V] = q[7] ^ c;
    t[FLAG_Z] = (q == 8'h00);
    return t;
  endfunction

  // Data memory for stack and Z addressed bytes
  cbt_dmem u_dmem (
    .clk_sys_i(clk_sys_i),
    .ce_i(ce_i),
    .wr_i(mem_wr),
    .addr_i(mem_addr),
    .wdata_i(mem_wdata),
    .rdata_o(mem_rdata)
  );

  // Next state
  always_comb begin
    r_next = r_reg;
    r_next.done = 1'b0;
    r_next.pm_wr = 1'b0;
    zptr = {r_reg.gpr[GPR_Z_HI], r_reg.gpr[GPR_Z_LO]};
    zsum = zptr + Z_STEP;
    src = r_reg.gpr[op_reg_i];
    res = 8'h00;
    mem_wr = 1'b0;
    mem_addr = zptr[DMEM_AW-1:0];
    mem_wdata = 8'h00;
    io_idx = 8'h00;
    case (r_reg.state)
      ST_IDLE: begin
        if (op_valid_i) begin
          r_next.op = op_code_i;
          r_next.rd = op_reg_i;
          r_next.done = 1'b1;
          case (op_code_i)
            OP_PM_WRITE: begin
              r_next.pm_wr = 1'b1;
              r_next.pm_addr = {r_reg.ext, zptr};
              r_next.pm_data = {r_reg.gpr[GPR_R1], r_reg.gpr[GPR_R0]};
              r_next.gpr[GPR_Z_LO] = zsum[7:0];
              r_next.gpr[GPR_Z_HI] = zsum[15:8];
            end
            OP_IO_READ: begin
              r_next.gpr[op_reg_i] = r_reg.io[op_io_addr_i];
            end
            OP_IO_WRITE: begin
              r_next.io[op_io_addr_i] = src;
            end
            OP_PUSH: begin
              mem_wr = 1'b1;
              mem_addr = r_reg.sp[DMEM_AW-1:0];
              mem_wdata = src;
              r_next.sp = r_reg.sp - 16'h0001;
            end
            OP_POP: begin
              // Read issued now, data lands next cycle
              r_next.sp = r_reg.sp + 16'h0001;
              mem_addr = r_next.sp[DMEM_AW-1:0];
              r_next.done = 1'b0;
              r_next.state = ST_MEM;
            end
            OP_OR_SWAP, OP_CLR_SWAP, OP_XOR_SWAP: begin
              // Read byte at Z, write back in the locked second step
              r_next.done = 1'b0;
              r_next.state = ST_MEM;
            end
            OP_ROT_LEFT: begin
              res = {src[6:0], r_reg.status_flags_register[FLAG_C]};
              r_next.gpr[op_reg_i] = res;
              r_next.status_flags_register = rot_flags(r_reg.status_flags_register, res, src[7]);
              r_next.status_flags_register[FLAG_H] = src[3];
            end
            OP_ROT_RIGHT: begin
              res = {r_reg.status_flags_register[FLAG_C], src[7:1]};
              r_next.gpr[op_reg_i] = res;
              r_next.status_flags_register = rot_flags(r_reg.status_flags_register, res, src[0]);
            end
            OP_IO_BIT_SET: begin
              r_next.io[op_io_addr_i] = put_bit(r_reg.io[op_io_addr_i], op_bit_i,
                                                1'b1);
            end
            OP_IO_BIT_CLR: begin
              r_next.io[op_io_addr_i] = put_bit(r_reg.io[op_io_addr_i], op_bit_i,
                                                1'b0);
            end
            OP_BIT_TO_T: begin
              r_next.status_flags_register[FLAG_T] = src[op_bit_i];
            end
            OP_T_TO_BIT: begin
              r_next.gpr[op_reg_i] = put_bit(src, op_bit_i, r_reg.status_flags_register[FLAG_T]);
            end
            OP_FLAG_WRITE: begin
              r_next.status_flags_register = put_bit(r_reg.status_flags_register, op_bit_i, op_flag_val_i);
            end
            default: begin
              r_next.done = 1'b0;
            end
          endcase
        end
      end
      ST_MEM: begin
        // Second step: data memory answer is valid now
        r_next.state = ST_IDLE;
        r_next.done = 1'b1;
        src = r_reg.gpr[r_reg.rd];
        if (r_reg.op == OP_POP) begin
          r_next.gpr[r_reg.rd] = mem_rdata;
        end else begin
          r_next.gpr[r_reg.rd] = mem_rdata;
          mem_wr = 1'b1;
          case (r_reg.op)
            OP_OR_SWAP: mem_wdata = src | mem_rdata;
            OP_CLR_SWAP: mem_wdata = ~src & mem_rdata;
            OP_XOR_SWAP: mem_wdata = src ^ mem_rdata;
            default: mem_wr = 1'b0;
          endcase
        end
      end
      default: begin
        r_next.state = ST_IDLE;
      end
    endcase

    // Software writes land after the operation
    if (sw_wr_i) begin
      if (sw_addr_i < SW_IO_BASE) begin
        r_next.gpr[sw_addr_i[4:0]] = sw_wdata_i;
      end else if (sw_addr_i <= SW_IO_END) begin
        io_idx = sw_addr_i - SW_IO_BASE;
        r_next.io[io_idx[5:0]] = sw_wdata_i;
      end else begin
        case (sw_addr_i)
          SW_STATUS_FLAGS_REGISTER: r_next.status_flags_register = sw_wdata_i;
          SW_EXT: r_next.ext = sw_wdata_i;
          SW_SP_LO: r_next.sp[7:0] = sw_wdata_i;
          SW_SP_HI: r_next.sp[15:8] = sw_wdata_i;
          default: ;
        endcase
      end
    end

    // Software read data, valid the next cycle
    r_next.rdata = 8'h00;
    if (sw_rd_i) begin
      if (sw_addr_i < SW_IO_BASE) begin
        r_next.rdata = r_reg.gpr[sw_addr_i[4:0]];
      end else if (sw_addr_i <= SW_IO_END) begin
        io_idx = sw_addr_i - SW_IO_BASE;
        r_next.rdata = r_reg.io[io_idx[5:0]];
      end else begin
        case (sw_addr_i)
          SW_STATUS_FLAGS_REGISTER: r_next.rdata = r_reg.status_flags_register;
          SW_EXT: r_next.rdata = r_reg.ext;
          SW_SP_LO: r_next.rdata = r_reg.sp[7:0];
          SW_SP_HI: r_next.rdata = r_reg.sp[15:8];
          SW_STATUS: r_next.rdata = {7'h00, r_reg.state != ST_IDLE};
          default: r_next.rdata = 8'h00;
        endcase
      end
    end
  end

  // State register
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      r_reg <= '0;
      r_reg.sp <= SP_RESET;
      r_reg.status_flags_register <= STATUS_FLAGS_REGISTER_RESET;
      r_reg.ext <= EXT_RESET;
    end else if (ce_i) begin
      r_reg <= r_next;
    end
  end

  // Outputs
  assign op_ready_o = (r_reg.state == ST_IDLE);
  assign op_done_o = r_reg.done;
  assign pm_wr_o = r_reg.pm_wr;
  assign pm_addr_o = r_reg.pm_addr;
  assign pm_data_o = r_reg.pm_data;
  assign sw_rdata_o = r_reg.rdata;
  assign status_flags_register_o = r_reg.status_flags_register;
endmodule

// ---- shared/cbt_pkg.sv ----
// Package of constants and types for the bit and transfer execution unit
package cbt_pkg;
  // Operation codes on the command port
  typedef enum logic [3:0] {
    OP_NONE = 4'h0,
    OP_PM_WRITE = 4'h1,
    OP_IO_READ = 4'h2,
    OP_IO_WRITE = 4'h3,
    OP_PUSH = 4'h4,
    OP_POP = 4'h5,
    OP_OR_SWAP = 4'h6,
    OP_CLR_SWAP = 4'h7,
    OP_XOR_SWAP = 4'h8,
    OP_ROT_LEFT = 4'h9,
    OP_ROT_RIGHT = 4'hA,
    OP_IO_BIT_SET = 4'hB,
    OP_IO_BIT_CLR = 4'hC,
    OP_BIT_TO_T = 4'hD,
    OP_T_TO_BIT = 4'hE,
    OP_FLAG_WRITE = 4'hF
  } cbt_op_t;

  // Sequencer states, Gray along idle to memory step
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_MEM = 2'b01
  } cbt_fsm_t;

  // Sizes
  localparam int GPR_COUNT = 32;
  localparam int IO_COUNT = 64;
  localparam int DMEM_DEPTH = 256;
  localparam int DMEM_AW = 8;

  // Status flag positions
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_T = 6;
  localparam int FLAG_I = 7;

  // Register pair positions
  localparam logic [4:0] GPR_R0 = 5'h00;
  localparam logic [4:0] GPR_R1 = 5'h01;
  localparam logic [4:0] GPR_Z_LO = 5'h1E;
  localparam logic [4:0] GPR_Z_HI = 5'h1F;
  localparam logic [15:0] Z_STEP = 16'h0002;

  // Software register map
  localparam logic [7:0] SW_GPR_BASE = 8'h00;
  localparam logic [7:0] SW_IO_BASE = 8'h20;
  localparam logic [7:0] SW_IO_END = 8'h5F;
  localparam logic [7:0] SW_STATUS_FLAGS_REGISTER = 8'h60;
  localparam logic [7:0] SW_EXT = 8'h61;
  localparam logic [7:0] SW_SP_LO = 8'h62;
  localparam logic [7:0] SW_SP_HI = 8'h63;
  localparam logic [7:0] SW_STATUS = 8'h64;

  // Reset values
  localparam logic [15:0] SP_RESET = 16'h00FF;
  localparam logic [7:0] STATUS_FLAGS_REGISTER_RESET = 8'h00;
  localparam logic [7:0] EXT_RESET = 8'h00;
endpackage

// ---- rtl/cbt_dmem.sv ----
// Small data memory with registered read data
`timescale 1ns/1ps
module cbt_dmem
  import cbt_pkg::*;
(
  // Clock and enable
  input wire logic clk_sys_i,
  input wire logic ce_i,
  // Access port
  input wire logic wr_i,
  input wire logic [DMEM_AW-1:0] addr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o
);
  logic [7:0] mem [DMEM_DEPTH];

  // Read first, read data registered: a write returns the old byte
  always_ff @(posedge clk_sys_i) begin
    if (ce_i) begin
      if (wr_i) begin
        mem[addr_i] <= wdata_i;
      end
      rdata_o <= mem[addr_i];
    end
  end
endmodule

// ---- test/cbt_pm_model.sv ----
// Program memory model keeping the last word written
`timescale 1ns/1ps
module cbt_pm_model (
  // Write port from the unit
  input wire logic clk_sys_i,
  input wire logic pm_wr_i,
  input wire logic [39:0] pm_word_i,
  // Last address and word stored
  output logic [39:0] last_o
);
  // Store on each write pulse
  always_ff @(posedge clk_sys_i) begin
    if (pm_wr_i) begin
      last_o <= pm_word_i;
    end
  end
endmodule

// ---- test/cbt_exec_checker.sv ----
// Checker of command timing and status flag effects
`timescale 1ns/1ps
module cbt_exec_checker
  import cbt_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Command port
  input wire logic ce_i,
  input wire logic op_valid_i,
  input wire cbt_op_t op_code_i,
  input wire logic [2:0] op_bit_i,
  input wire logic op_flag_val_i,
  input wire logic op_ready_o,
  input wire logic op_done_o,
  // Program write and status
  input wire logic pm_wr_o,
  input wire logic [23:0] pm_addr_o,
  input wire logic sw_wr_i,
  input wire logic [7:0] status_flags_register_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  // Request taken with no software write beside it
  logic tk;
  logic two;
  assign tk = ce_i && op_valid_i && op_ready_o && !sw_wr_i;
  assign two = op_code_i inside {OP_POP, OP_OR_SWAP, OP_CLR_SWAP, OP_XOR_SWAP};
  // Locked second step, then done
  sequence s_two;
    !op_ready_o ##1 (op_done_o && op_ready_o);
  endsequence
  one_cycle_a: assert property (tk && !two && op_code_i != OP_NONE |=> op_done_o)
    else $error("Done late");
  two_step_a: assert property (tk && two |=> s_two) else $error("Two steps wrong");
  no_flag_a: assert property (tk && op_code_i inside {OP_IO_READ, OP_IO_WRITE,
    OP_PUSH, OP_IO_BIT_SET, OP_IO_BIT_CLR, OP_T_TO_BIT} |=> $stable(status_flags_register_o))
    else $error("Flags moved");
  flag_write_a: assert property (tk && op_code_i == OP_FLAG_WRITE |=>
    status_flags_register_o == (($past(status_flags_register_o) & ~(8'h01 << $past(op_bit_i)))
    | ({7'h00, $past(op_flag_val_i)} << $past(op_bit_i)))) else $error("Flag write wrong");
  bit_t_a: assert property (tk && op_code_i == OP_BIT_TO_T |=>
    ((status_flags_register_o ^ $past(status_flags_register_o)) & 8'hBF) == 8'h00) else $error("Bit store moved flags");
  rot_flags_a: assert property (tk && op_code_i inside {OP_ROT_LEFT, OP_ROT_RIGHT} |=>
    status_flags_register_o[FLAG_V] == (status_flags_register_o[FLAG_N] ^ status_flags_register_o[FLAG_C])
    && ((status_flags_register_o ^ $past(status_flags_register_o)) & 8'hD0) == 8'h00) else $error("Rotate flags wrong");
  pm_pulse_a: assert property (pm_wr_o |->
    $past(ce_i && op_valid_i && op_ready_o && op_code_i == OP_PM_WRITE)) else $error("Stray write");
  pm_step_a: assert property (pm_wr_o && $past(pm_wr_o, 2) && !$past(sw_wr_i)
    && !$past(sw_wr_i, 2) && !$past(sw_wr_i, 3)
    |-> pm_addr_o[15:0] == $past(pm_addr_o[15:0], 2) + Z_STEP) else $error("Bad step");
endmodule
// Attach to every execution unit
bind cbt_exec cbt_exec_checker u_cbt_exec_checker (.clk_sys_i, .rst_i, .ce_i, .op_valid_i,
  .op_code_i, .op_bit_i, .op_flag_val_i, .op_ready_o, .op_done_o, .pm_wr_o, .pm_addr_o,
  .sw_wr_i, .status_flags_register_o);

// ---- test/tb_top.sv ----
// Random and corner case bench for the execution unit
`timescale 1ns/1ps
module tb_top
  import cbt_pkg::*;
;
  // Inputs, valued at time zero
  logic clk_sys_i = 1'h0, rst_i = 1'h1, ce_i = 1'h1, op_valid_i = 1'h0, op_flag_val_i = 1'h0;
  cbt_op_t op_code_i = OP_NONE;
  logic [4:0] op_reg_i = 5'h00;
  logic [5:0] op_io_addr_i = 6'h00;
  logic [2:0] op_bit_i = 3'h0;
  logic [7:0] sw_addr_i = 8'h00, sw_wdata_i = 8'h00;
  logic sw_wr_i = 1'h0, sw_rd_i = 1'h0;
  // Outputs and bench state
  logic op_ready_o, op_done_o, pm_wr_o;
  logic [23:0] pm_addr_o;
  logic [15:0] pm_data_o;
  logic [7:0] sw_rdata_o, status_flags_register_o;
  logic [39:0] pm_last;
  logic [31:0] rnd = 32'h193AC430;
  int mismatches = 0, tests_run = 0, cycles = 0;
  cbt_exec u_cbt_exec (.clk_sys_i, .rst_i, .ce_i, .op_valid_i, .op_code_i, .op_reg_i,
    .op_io_addr_i, .op_bit_i, .op_flag_val_i, .op_ready_o, .op_done_o, .pm_wr_o, .pm_addr_o,
    .pm_data_o, .sw_addr_i, .sw_wdata_i, .sw_wr_i, .sw_rd_i, .sw_rdata_o, .status_flags_register_o);
  cbt_pm_model u_cbt_pm_model (.clk_sys_i, .pm_wr_i(pm_wr_o),
    .pm_word_i({pm_addr_o, pm_data_o}), .last_o(pm_last));
  // Clock of 10 ns
  initial begin
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  // Cut a hang short
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      finish_test();
    end
  end
  // Next random byte
  function automatic logic [7:0] rb();
    rnd = {rnd[30:0], rnd[31] ^ rnd[21] ^ rnd[1] ^ rnd[0]};
    return rnd[7:0];
  endfunction
  // Rotate through carry: new register and status
  function automatic logic [15:0] rot(input logic [7:0] x, input logic [7:0] s, input logic l);
    logic [7:0] n;
    n = l ? {x[6:0], s[FLAG_C]} : {s[FLAG_C], x[7:1]};
    s[FLAG_C] = l ? x[7] : x[0];
    s[FLAG_Z] = (n == 8'h00);
    s[FLAG_N] = n[7];
    s[FLAG_V] = n[7] ^ s[FLAG_C];
    s[FLAG_H] = l ? x[3] : s[FLAG_H];
    return {n, s};
  endfunction
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Software port write and checked read
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    sw_addr_i <= a;
    sw_wdata_i <= d;
    sw_wr_i <= 1'h1;
    @(posedge clk_sys_i);
    sw_wr_i <= 1'h0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_sys_i);
    sw_addr_i <= a;
    sw_rd_i <= 1'h1;
    @(posedge clk_sys_i);
    sw_rd_i <= 1'h0;
    #1 chk({16'h0000, sw_rdata_o}, {16'h0000, e});
  endtask
  // One command, waiting the documented step count
  task automatic op(input cbt_op_t c, input logic [4:0] r, input logic [2:0] b);
    @(posedge clk_sys_i);
    op_valid_i <= 1'h1;
    op_code_i <= c;
    op_reg_i <= r;
    op_bit_i <= b;
    @(posedge clk_sys_i);
    op_valid_i <= 1'h0;
    if (c inside {OP_POP, OP_OR_SWAP, OP_CLR_SWAP, OP_XOR_SWAP}) begin
      @(posedge clk_sys_i);
    end
    #1 chk({23'h000000, op_done_o}, 24'h000001);
  endtask
  initial begin
    logic [7:0] a, m, c, x, s, e, mv;
    logic [7:0] q [4];
    repeat (4) @(posedge clk_sys_i);
    rst_i <= 1'h0;
    rchk(SW_SP_LO, SP_RESET[7:0]);
    wr(8'h70, 8'hA5);
    rchk(8'h70, 8'h00);
    $display("Reset test done");
    a = rb();
    m = rb();
    c = rb();
    wr(8'h00, a);
    wr(8'h01, m);
    wr(SW_EXT, c);
    wr(8'h1E, 8'hFF);
    wr(8'h1F, 8'hFF);
    op(OP_PM_WRITE, 5'h00, 3'h0);
    chk(pm_addr_o, {c, 16'hFFFF});
    chk({8'h00, pm_data_o}, {8'h00, m, a});
    op(OP_PM_WRITE, 5'h00, 3'h0);
    rchk(8'h1E, 8'h03);
    chk(pm_last[39:16], {c, 16'h0001});
    $display("Program write test done");
    for (int i = 0; i < 8; i++) begin
      x = rb();
      wr(8'h05, x);
      op_io_addr_i <= (i == 0) ? 6'h3F : x[7:2];
      op(OP_IO_WRITE, 5'h05, 3'h0);
      op(i[0] ? OP_IO_BIT_SET : OP_IO_BIT_CLR, 5'h00, x[2:0]);
      e = i[0] ? (x | (8'h01 << x[2:0])) : (x & ~(8'h01 << x[2:0]));
      rchk(SW_IO_BASE + {2'h0, op_io_addr_i}, e);
      op(OP_IO_READ, 5'h06, 3'h0);
      rchk(8'h06, e);
      op(OP_BIT_TO_T, 5'h06, ~x[2:0]);
      op(OP_T_TO_BIT, 5'h05, x[2:0]);
      x[x[2:0]] = e[~x[2:0]];
      rchk(8'h05, x);
    end
    $display("I/O and bit test done");
    for (int i = 0; i < 16; i++) begin
      s = rb();
      wr(SW_STATUS_FLAGS_REGISTER, s);
      op_flag_val_i <= i[3];
      op(OP_FLAG_WRITE, 5'h00, i[2:0]);
      s[i[2:0]] = i[3];
      rchk(SW_STATUS_FLAGS_REGISTER, s);
    end
    $display("Flag test done");
    for (int i = 0; i < 8; i++) begin
      x = (i == 2) ? 8'h00 : rb();
      s = (i == 2) ? 8'h00 : rb();
      wr(8'h09, x);
      wr(SW_STATUS_FLAGS_REGISTER, s);
      op(i[0] ? OP_ROT_LEFT : OP_ROT_RIGHT, 5'h09, 3'h0);
      {e, s} = rot(x, s, i[0]);
      rchk(8'h09, e);
      rchk(SW_STATUS_FLAGS_REGISTER, s);
    end
    $display("Rotate test done");
    for (int i = 0; i < 4; i++) begin
      q[i] = rb();
      wr(8'h0A, q[i]);
      op(OP_PUSH, 5'h0A, 3'h0);
    end
    rchk(SW_SP_LO, 8'hFB);
    for (int i = 3; i >= 0; i--) begin
      op(OP_POP, 5'h0B, 3'h0);
      rchk(8'h0B, q[i]);
    end
    $display("Stack test done");
    wr(8'h1E, 8'hFC);
    mv = q[3];
    for (int i = 0; i < 12; i++) begin
      x = rb();
      wr(8'h0C, x);
      op(cbt_op_t'(OP_OR_SWAP + i % 3), 5'h0C, 3'h0);
      rchk(8'h0C, mv);
      mv = (i % 3 == 0) ? (x | mv) : (i % 3 == 1) ? (mv & ~x) : (x ^ mv);
    end
    $display("Swap test done");
    finish_test();
  end
endmodule
